// ### bench/cpt_far_model.sv
// arbitration core side: radio activity, live radio class and completion reports
`timescale 1ns/1ps
module cpt_far_model
   import cpt_pkg::*;
(
   // clock
   input wire logic core_clk,
   // towards the table
   output logic radio_active,
   output logic [2:0] radio_mac_class,
   output cpt_pkg::cpt_done_type done_event
);
   // quiet lines at time zero
   initial begin
      radio_active = 1'h0;
      radio_mac_class = 3'h0;
      done_event = '0;
   end

   // only whole-cycle moves; callers keep the tag alone while active
   task automatic drive(input logic act, input logic [2:0] cls);
      @(posedge core_clk);
      radio_active <= act;
      radio_mac_class <= cls;
   endtask

   // one-cycle report; fields inverted after so stale values never look valid
   task automatic complete(input logic [1:0] o, input logic tx, input logic p);
      @(posedge core_clk);
      done_event <= '{1'h1, o, tx, p};
      @(posedge core_clk);
      done_event <= '{1'h0, ~o, ~tx, ~p};
   endtask
endmodule

// ### bench/cpt_tb_top.sv
// self-checking bench for the coexistence priority table
`timescale 1ns/1ps
module cpt_tb_top;
   import cpt_pkg::*;
   logic core_clk = 1'h0;
   logic reset = 1'h1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic radio_active, class_source_select;
   logic [2:0] radio_mac_class, radio_class_eff;
   logic [3:0] radio_pri_index, ext_pri_index;
   cpt_done_type done_event;
   cpt_entry_type priority_table [CPT_ENTRY_COUNT];
   int miscompares = 0;
   int checks = 0;

   always #5 core_clk = ~core_clk;

   cpt_top dut (.*);
   cpt_far_model far (.*);

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // byte address keeps only the low bits of index times four
   function automatic logic [31:0] adr(input logic [31:0] idx);
      return {idx[29:0], 2'h0};
   endfunction

   task automatic wr(input logic [31:0] idx, input logic [31:0] d, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= adr(idx);
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask

   task automatic rd(input logic [31:0] idx, input logic [31:0] exp, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= adr(idx);
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk("rdata", exp, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask

   // class latch, then effective class and index registers: two edges needed, three waited
   task automatic settle();
      repeat (3) @(posedge core_clk);
   endtask

   task automatic t_reset();
      logic [1:0] own [3] = '{2'h3, 2'h1, 2'h2};
      for (int k = 0; k < 14; k++) begin
         rd(CPT_IDX_ENTRY[k], (k < 3) ? {27'h0, own[k], 3'h0} : 32'h0, 2'h0);
      end
      rd(CPT_IDX_CLASS_TAG, 32'h0, 2'h0);
      chk("ext index", 32'h3, {28'h0, ext_pri_index});
      chk("radio index", 32'h2, {28'h0, radio_pri_index});
      $display("done reset test");
   endtask

   task automatic t_fields();
      wr(CPT_IDX_ENTRY[4], 32'hffff_ffff, 2'h0);
      rd(CPT_IDX_ENTRY[4], 32'h0000_001f, 2'h0);
      chk("entry 5", 32'h1f, {27'h0, priority_table[4]});
      s_axi_wstrb <= 4'he;
      wr(CPT_IDX_ENTRY[4], 32'h0000_0000, 2'h0);
      s_axi_wstrb <= 4'hf;
      rd(CPT_IDX_ENTRY[4], 32'h0000_001f, 2'h0);
      wr(CPT_IDX_CLASS_TAG, 32'hffff_fff8, 2'h0);
      rd(CPT_IDX_CLASS_TAG, 32'h0, 2'h0);
      wr(32'h0000_00ff, 32'hffff_ffff, 2'h2);
      rd(32'h0000_00ff, 32'h0, 2'h2);
      $display("done field test");
   endtask

   task automatic t_match();
      wr(CPT_IDX_ENTRY[3], 32'h0000_0010, 2'h0);
      wr(CPT_IDX_ENTRY[2], 32'h0000_0015, 2'h0);
      wr(CPT_IDX_ENTRY[6], 32'h0000_000d, 2'h0);
      wr(CPT_IDX_CLASS_TAG, 32'h0000_0005, 2'h0);
      chk("entry 7", 32'h0d, {27'h0, priority_table[6]});
      settle();
      chk("ext index", 32'h4, {28'h0, ext_pri_index});
      chk("radio index", 32'h2, {28'h0, radio_pri_index});
      far.drive(1'h1, 3'h0);
      settle();
      chk("radio index", 32'h7, {28'h0, radio_pri_index});
      far.drive(1'h0, 3'h0);
      wr(CPT_IDX_CLASS_TAG, 32'h0000_0003, 2'h0);
      far.drive(1'h1, 3'h0);
      settle();
      chk("radio index", 32'h0, {28'h0, radio_pri_index});
      far.drive(1'h0, 3'h0);
      wr(CPT_IDX_CTRL, 32'h0000_0001, 2'h0);
      chk("select", 32'h1, {31'h0, class_source_select});
      rd(CPT_IDX_CTRL, 32'h0000_0001, 2'h0);
      far.drive(1'h0, 3'h5);
      settle();
      chk("class eff", 32'h5, {29'h0, radio_class_eff});
      chk("radio index", 32'h7, {28'h0, radio_pri_index});
      far.complete(2'h1, 1'h0, 1'h1);
      rd(CPT_IDX_MONITOR, 32'h0000_0047, 2'h0);
      far.drive(1'h0, 3'h7);
      settle();
      far.complete(2'h1, 1'h1, 1'h1);
      rd(CPT_IDX_MONITOR, 32'h0, 2'h0);
      wr(CPT_IDX_CTRL, 32'h0, 2'h0);
      chk("select", 32'h0, {31'h0, class_source_select});
      $display("done lookup test");
   endtask

   task automatic t_monitor();
      far.complete(2'h2, 1'h1, 1'h1);
      rd(CPT_IDX_MONITOR, 32'h0000_0064, 2'h0);
      rd(CPT_IDX_MONITOR, 32'h0, 2'h0);
      far.complete(2'h2, 1'h0, 1'h0);
      far.complete(2'h2, 1'h0, 1'h0);
      rd(CPT_IDX_MONITOR, 32'h0000_0084, 2'h0);
      $display("done monitor test");
   endtask

   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      #20000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'h0;
      t_reset();
      t_fields();
      t_match();
      t_monitor();
      report_and_stop();
   end
endmodule

// ### bench/cpt_top_asserts.sv
// checker for bus handshakes, reset table and class lookup of the priority table
`timescale 1ns/1ps
module cpt_top_asserts
   import cpt_pkg::*;
(
   // clock and reset
   input logic core_clk,
   input logic reset,
   // register bus
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic [31:0] s_axi_rdata,
   // radio and completion
   input logic radio_active,
   input logic [2:0] radio_mac_class,
   input cpt_pkg::cpt_done_type done_event,
   // lookup side
   input cpt_pkg::cpt_entry_type priority_table [cpt_pkg::CPT_ENTRY_COUNT],
   input logic class_source_select,
   input logic [2:0] radio_class_eff,
   input logic [3:0] radio_pri_index,
   input logic [3:0] ext_pri_index
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // bus handshakes
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write not answered two cycles after take");
   a_aw_refused: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
      else $error("write address accepted while busy");
   a_b_once: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered one cycle after take");
   a_rd_reserved: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("reserved read bits not zero");
   // reset table and its first lookup
   a_reset_owners: assert property (
      $fell(reset) |-> priority_table[0].owner == 2'h3 && priority_table[1].owner == 2'h1
         && priority_table[2].owner == 2'h2 && priority_table[3].owner == 2'h0)
      else $error("entry owners wrong after reset");
   a_reset_lookup: assert property (
      $fell(reset) |=> ext_pri_index == 4'h3 && radio_pri_index == 4'h2)
      else $error("indices wrong after reset");
   // class source: live class one cycle behind, latched tag steady mid transaction
   a_select_live: assert property (
      class_source_select && $past(class_source_select)
         |-> radio_class_eff == $past(radio_mac_class))
      else $error("live radio class not followed");
   a_tag_held: assert property (
      radio_active && $past(radio_active) && !class_source_select
         && !$past(class_source_select)
         |-> ##2 ($past(class_source_select) || $stable(radio_class_eff)))
      else $error("latched class moved without a new transaction");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && !s_axi_arready);
   c_radio_rise: cover property ($rose(radio_active));
   c_done: cover property (done_event.valid);
endmodule

bind cpt_top cpt_top_asserts u_chk (.*);

// ### core/cpt_entry_match.sv
// one priority entry compared against a packet's owner and class
`timescale 1ns/1ps
module cpt_entry_match
   import cpt_pkg::*;
(
   // entry contents
   input wire cpt_pkg::cpt_entry_type entry,
   // packet being classified
   input wire logic [1:0] owner,
   input wire logic [2:0] cls,
   // result
   output logic hit
);
   // both owner and class must agree
   assign hit = (entry.owner == owner) && (entry.cls == cls);
endmodule

// ### core/cpt_pkg.sv
// package: register map, field layout and carriers of the coexistence priority table
package cpt_pkg;

   // sizes
   localparam int unsigned CPT_REG_WIDTH = 16;
   localparam int unsigned CPT_ENTRY_COUNT = 14;
   localparam int unsigned CPT_INDEX_WIDTH = 4;
   localparam int unsigned CPT_CLASS_WIDTH = 3;
   localparam int unsigned CPT_OWNER_WIDTH = 2;
   // only the low byte-address bits are decoded; the upper bits alias
   localparam int unsigned CPT_DEC_WIDTH = 10;

   // register indices; byte address is four times the index
   localparam logic [31:0] CPT_IDX_CTRL = 32'h5000_2f02;
   localparam logic [31:0] CPT_IDX_MONITOR = 32'h5000_2f04;
   localparam logic [31:0] CPT_IDX_CLASS_TAG = 32'h5000_2f0a;
   localparam logic [31:0] CPT_IDX_ENTRY [CPT_ENTRY_COUNT] = '{
      32'h5000_2f12, 32'h5000_2f14, 32'h5000_2f16, 32'h5000_2f18,
      32'h5000_2f1a, 32'h5000_2f1c, 32'h5000_2f1e, 32'h5000_2f20,
      32'h5000_2f22, 32'h5000_2f24, 32'h5000_2f26, 32'h5000_2f28,
      32'h5000_2f2a, 32'h5000_2f2c};

   // field positions
   localparam int unsigned CPT_CLASS_LSB = 0;
   localparam int unsigned CPT_OWNER_LSB = 3;
   localparam int unsigned CPT_ENTRY_BITS = 5;
   localparam int unsigned CPT_CTRL_SEL_BIT = 0;
   localparam int unsigned CPT_MON_BITS = 8;

   // owner encoding shared with the arbitration winner (values arbitrary here)
   localparam logic [1:0] CPT_OWNER_RADIO = 2'h1;
   localparam logic [1:0] CPT_OWNER_EXT = 2'h2;
   localparam logic [2:0] CPT_EXT_CLASS = 3'h0;

   // reset values
   localparam logic [1:0] CPT_OWNER_RESET [CPT_ENTRY_COUNT] = '{
      2'h3, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0,
      2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
   localparam logic [2:0] CPT_CLASS_RESET = 3'h0;
   localparam logic [2:0] CPT_TAG_RESET = 3'h0;
   localparam logic CPT_SEL_RESET = 1'b0;

   // bus answers
   localparam logic [1:0] CPT_RESP_OKAY = 2'h0;
   localparam logic [1:0] CPT_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] owner;
      logic [2:0] cls;
   } cpt_entry_type;

   typedef struct packed {
      logic overwrite;
      logic passed;
      logic is_tx;
      logic spare;
      logic [3:0] ptr;
   } cpt_monitor_type;

   typedef struct packed {
      logic valid;
      logic [1:0] owner;
      logic is_tx;
      logic passed;
   } cpt_done_type;

endpackage

// ### core/cpt_top.sv
// coexistence priority table: registers over AXI4-Lite, entry matching, completion monitor
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module cpt_top
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // axi4-lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // radio MAC side
   input wire logic radio_active,
   input wire logic [2:0] radio_mac_class,
   // completion events from the arbitration core
   input wire cpt_pkg::cpt_done_type done_event,
   // towards the arbitration core
   output cpt_pkg::cpt_entry_type priority_table [cpt_pkg::CPT_ENTRY_COUNT],
   output logic class_source_select,
   output logic [2:0] radio_class_eff,
   output logic [3:0] radio_pri_index,
   output logic [3:0] ext_pri_index
);
   import cpt_pkg::*;

   // register state
   // the tag written by software, and the copy frozen for the running transaction
   logic [2:0] next_txn_class_tag;
   logic [2:0] latched_tag;
   logic radio_active_q;
   cpt_monitor_type monitor;

   // write channel state
   // each half of a write is held on its own until the response is taken
   logic aw_held;
   logic w_held;
   logic next_aw_held;
   logic next_w_held;
   logic [CPT_DEC_WIDTH-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic write_fire;
   logic b_done;

   // read channel state
   logic ar_take;
   logic r_done;
   logic [31:0] read_word;
   logic read_hit;
   logic mon_read;

   // matching
   logic [2:0] class_now;
   logic [CPT_ENTRY_COUNT-1:0] radio_hits;
   logic [CPT_ENTRY_COUNT-1:0] ext_hits;
   logic [CPT_ENTRY_COUNT-1:0] done_hits;
   logic [2:0] done_class;
   logic [3:0] done_index;

   // byte address of a register index, cut to the decoded bits
   // the full index times four overflows 32 bits, so only the decoded bits are kept
   function automatic logic [CPT_DEC_WIDTH-1:0] byte_addr(input logic [31:0] idx);
      logic [33:0] full;
      full = {idx, 2'b00};
      return full[CPT_DEC_WIDTH-1:0];
   endfunction

   // lowest entry number wins; zero means no entry matched
   // overlapping entries are legal; software sets precedence by entry order
   function automatic logic [3:0] first_hit(input logic [CPT_ENTRY_COUNT-1:0] hits);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = CPT_ENTRY_COUNT - 1; i >= 0; i--) begin
         if (hits[i]) begin
            idx = 4'(i + 1);
         end
      end
      return idx;
   endfunction

   // write channel handshakes
   // write_fire lasts one cycle: bvalid rises at its end and masks it
   assign b_done = s_axi_bvalid && s_axi_bready;
   assign write_fire = aw_held && w_held && !s_axi_bvalid;

   // address and data may arrive in either order; each is held until the response
   // a held half is never dropped early, so a slow data phase cannot lose the address
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
      end else if (b_done) begin
         next_aw_held = 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
      end else if (b_done) begin
         next_w_held = 1'b0;
      end
   end

   // ready drops while a write is pending, so one write at a time
   // limitation: no pipelining, back-to-back writes cost two dead cycles each
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         s_axi_awready <= !next_aw_held;
         s_axi_wready <= !next_w_held;
      end
   end

   // captured address and data
   // upper address bits are ignored, so the map repeats every 1 KiB
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr[CPT_DEC_WIDTH-1:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   // write response; unmapped addresses answer with an error and change nothing
   // the answer depends on decode alone; strobes never change it
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CPT_RESP_OKAY;
      end else if (write_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= CPT_RESP_SLVERR;
         if (aw_addr == byte_addr(CPT_IDX_CTRL) || aw_addr == byte_addr(CPT_IDX_CLASS_TAG)
               || aw_addr == byte_addr(CPT_IDX_MONITOR)) begin
            s_axi_bresp <= CPT_RESP_OKAY;
         end
         for (int i = 0; i < CPT_ENTRY_COUNT; i++) begin
            if (aw_addr == byte_addr(CPT_IDX_ENTRY[i])) begin
               s_axi_bresp <= CPT_RESP_OKAY;
            end
         end
      end else if (b_done) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // class tag and source select; only lane 0 holds live bits
   // a write with lane 0 disabled still answers okay but changes nothing
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         next_txn_class_tag <= CPT_TAG_RESET;
         class_source_select <= CPT_SEL_RESET;
      end else if (write_fire && w_strb[0]) begin
         if (aw_addr == byte_addr(CPT_IDX_CLASS_TAG)) begin
            next_txn_class_tag <= w_data[2:0];
         end
         if (aw_addr == byte_addr(CPT_IDX_CTRL)) begin
            class_source_select <= w_data[CPT_CTRL_SEL_BIT];
         end
      end
   end

   // priority entries; the monitor register is read-only, writes to it do nothing
   // whole entry written at once, so owner and class never disagree mid-update
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < CPT_ENTRY_COUNT; i++) begin
            priority_table[i].owner <= CPT_OWNER_RESET[i];
            priority_table[i].cls <= CPT_CLASS_RESET;
         end
      end else if (write_fire && w_strb[0]) begin
         for (int i = 0; i < CPT_ENTRY_COUNT; i++) begin
            if (aw_addr == byte_addr(CPT_IDX_ENTRY[i])) begin
               // bits above 4 are dropped
               priority_table[i] <= w_data[CPT_ENTRY_BITS-1:0];
            end
         end
      end
   end

   // read channel handshakes
   // mon_read marks the edge at which the monitor is cleared
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign r_done = s_axi_rvalid && s_axi_rready;
   assign mon_read = ar_take && (s_axi_araddr[CPT_DEC_WIDTH-1:0] == byte_addr(CPT_IDX_MONITOR));

   // read decode; reserved bits come back as zero
   // unmapped reads give zero data and a slave error
   always_comb begin
      read_word = 32'h0000_0000;
      read_hit = 1'b0;
      if (s_axi_araddr[CPT_DEC_WIDTH-1:0] == byte_addr(CPT_IDX_CLASS_TAG)) begin
         read_word[2:0] = next_txn_class_tag;
         read_hit = 1'b1;
      end
      if (s_axi_araddr[CPT_DEC_WIDTH-1:0] == byte_addr(CPT_IDX_CTRL)) begin
         read_word[CPT_CTRL_SEL_BIT] = class_source_select;
         read_hit = 1'b1;
      end
      if (s_axi_araddr[CPT_DEC_WIDTH-1:0] == byte_addr(CPT_IDX_MONITOR)) begin
         read_word[CPT_MON_BITS-1:0] = monitor;
         read_hit = 1'b1;
      end
      for (int i = 0; i < CPT_ENTRY_COUNT; i++) begin
         if (s_axi_araddr[CPT_DEC_WIDTH-1:0] == byte_addr(CPT_IDX_ENTRY[i])) begin
            read_word[CPT_ENTRY_BITS-1:0] = priority_table[i];
            read_hit = 1'b1;
         end
      end
   end

   // data is sampled at the address edge, so a later write never tears it
   // arready stays low while rvalid stands: one read in flight
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= CPT_RESP_OKAY;
      end else begin
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_hit ? CPT_RESP_OKAY : CPT_RESP_SLVERR;
         end else if (r_done) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // the tag is frozen at the start of each radio transaction
   // a tag written in the very cycle of the rise misses that transaction
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         radio_active_q <= 1'b0;
         latched_tag <= CPT_TAG_RESET;
      end else begin
         radio_active_q <= radio_active;
         if (radio_active && !radio_active_q) begin
            // software is trusted not to move the tag mid-transaction
            latched_tag <= next_txn_class_tag;
         end
      end
   end

   // effective radio class: latched tag, or the MAC's own class lines
   // the select may change at any time; the registered lookups follow one cycle later, the completion lookup at once
   assign class_now = class_source_select ? radio_mac_class : latched_tag;

   // completion class: external traffic is always class zero
   // owners 0 and 3 fall back to the radio class
   assign done_class = (done_event.owner == CPT_OWNER_EXT) ? CPT_EXT_CLASS : class_now;

   // one comparator per entry for each of the three lookups
   // area traded for a shallow path: no shared comparator, no sequencing
   for (genvar g = 0; g < CPT_ENTRY_COUNT; g++) begin : g_match
      cpt_entry_match radio_match (
         .entry(priority_table[g]),
         .owner(CPT_OWNER_RADIO),
         .cls(class_now),
         .hit(radio_hits[g])
      );
      cpt_entry_match ext_match (
         .entry(priority_table[g]),
         .owner(CPT_OWNER_EXT),
         .cls(CPT_EXT_CLASS),
         .hit(ext_hits[g])
      );
      cpt_entry_match done_match (
         .entry(priority_table[g]),
         .owner(done_event.owner),
         .cls(done_class),
         .hit(done_hits[g])
      );
   end

   // completion lookup is combinational; the monitor register holds its result
   assign done_index = first_hit(done_hits);

   // registered lookups; one cycle behind any table or class change
   // index zero doubles as no match, so entry numbers start at one
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         radio_class_eff <= CPT_TAG_RESET;
         radio_pri_index <= 4'h0;
         ext_pri_index <= 4'h0;
      end else begin
         radio_class_eff <= class_now;
         radio_pri_index <= first_hit(radio_hits);
         ext_pri_index <= first_hit(ext_hits);
      end
   end

   // completion monitor; a new report beats a clearing read in the same cycle
   // overwrite stays set until software reads the monitor
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         monitor <= '0;
      end else if (done_event.valid && done_index != 4'h0) begin
         monitor.ptr <= done_index;
         monitor.is_tx <= done_event.is_tx;
         monitor.passed <= done_event.passed;
         monitor.spare <= 1'b0;
         // overwrite only if an unread report is lost
         monitor.overwrite <= !mon_read && (monitor.overwrite || monitor.ptr != 4'h0);
      end else if (mon_read) begin
         monitor <= '0;
      end
      // unmatched completions fall through and leave the monitor alone
   end

endmodule
